// *** design/mode_switch_compat_mover.sv ***
// Purpose: Mode switching between emulation and native mode, plus the four
//          storage-to-storage move and load operations.
// Assumes: All inputs come from logic on ref_clk; storage holds req until ack.
// Notes:   Emulated storage characters carry a word mark bit beside the data.
`timescale 1ns/1ps

// Operation
// - Mask bytes 9C and 9D gate switching
// - Nine selectable causes switch modes
// - Switch is supervisor call, status words swapped
// - Cause code into old status bits 24-31
// - Store instruction address except error stops
// - Back up emulated registers at switch
// - Only mode set instruction returns to emulation
// - Move-to uses source, destination, 16-bit count
// - Move-to keeps destination word marks untouched
// - Each byte bumps addresses, drops count
// - Zero count ends move-to, group mark written
// - Destination group mark word mark ends move-to
// - Destination one past end, loaded into B
// - Move-from stops on source group mark word mark
// - Load-to clears written destination word marks
// - Load-to separator skips, marks next character
// - Load-to ends like move-to, B gets destination
// - Load-from word mark emits separator first
// - Load-from stops on source group mark word mark
module mode_switch_compat_mover
  import compat_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // Local storage byte access for the mask.
  input  wire logic                      ls_we,
  input  wire logic                      ls_re,
  input  wire logic [7:0]                ls_addr,
  input  wire logic [7:0]                ls_wdata,
  output logic      [7:0]                ls_rdata_r,
  // Emulation traps and the mode set instruction.
  input  wire logic                      trap_event,
  input  wire logic [3:0]                trap_cause,
  input  wire logic                      trap_error_noaddr,
  input  wire logic [EMU_ADDR_WIDTH-1:0] emu_instr_addr,
  input  wire logic [EMU_ADDR_WIDTH-1:0] emu_a_in,
  input  wire logic [EMU_ADDR_WIDTH-1:0] emu_b_in,
  input  wire logic [63:0]               cur_psw,
  input  wire logic                      mode_set_instr,
  output logic                           emu_mode_r,
  output logic                           psw_swap_r,
  output logic      [63:0]               old_psw_r,
  output logic                           local_trap_r,
  output logic                           backup_we_r,
  output logic      [EMU_ADDR_WIDTH-1:0] backup_a_r,
  output logic      [EMU_ADDR_WIDTH-1:0] backup_b_r,
  // Move and load command from the native program.
  input  wire logic                      op_start,
  input  move_op_type                    op_kind,
  input  wire logic [ADDR_WIDTH-1:0]     op_src,
  input  wire logic [ADDR_WIDTH-1:0]     op_dst,
  input  wire logic [CNT_WIDTH-1:0]      op_count,
  output logic                           op_busy_r,
  output logic                           op_done_r,
  output logic      [1:0]                op_cc_r,
  output logic      [ADDR_WIDTH-1:0]     src_reg_r,
  output logic      [ADDR_WIDTH-1:0]     dst_reg_r,
  output logic      [CNT_WIDTH-1:0]      cnt_reg_r,
  output logic                           b_load_r,
  output logic      [ADDR_WIDTH-1:0]     b_value_r,
  // Main storage port.
  output logic                           mem_req_r,
  output logic                           mem_we_r,
  output logic      [ADDR_WIDTH-1:0]     mem_addr_r,
  output logic      [7:0]                mem_wdata_r,
  output logic                           mem_wm_we_r,
  output logic                           mem_wm_r,
  input  wire logic                      mem_ack,
  input  wire logic [7:0]                mem_rdata,
  input  wire logic                      mem_rwm
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_RD_DST,
    ST_RD_SRC,
    ST_WR_DAT,
    ST_WR_SEP,
    ST_WR_GM,
    ST_FINISH
  } mover_state_type;

  mover_state_type state_r;
  move_op_type     kind_r;
  logic [7:0]      mask_high_r;
  logic [7:0]      mask_low_r;
  logic            pend_wm_r;
  logic            sep_done_r;
  logic            to_op;
  logic            is_group_mark_with_word_mark;

  switch_if sw ();

  switch_decider u_decider (
    .sw (sw.decide)
  );

  assign sw.mask  = {mask_high_r, mask_low_r};
  assign sw.cause = trap_cause;

  assign to_op   = (kind_r == OP_MOVE_TO) || (kind_r == OP_LOAD_TO);
  assign is_group_mark_with_word_mark = mem_rwm && (mem_rdata == GROUP_MARK_CHAR);

  // Mask bytes live at their local storage offsets; other offsets read zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_high_r <= MASK_RESET;
      mask_low_r  <= MASK_RESET;
      ls_rdata_r  <= 8'h00;
    end else begin
      if (ls_we && ls_addr == MASK_HIGH_OFFSET) begin
        mask_high_r <= ls_wdata;
      end
      if (ls_we && ls_addr == MASK_LOW_OFFSET) begin
        mask_low_r <= ls_wdata;
      end
      if (ls_re) begin
        unique case (ls_addr)
          MASK_HIGH_OFFSET: ls_rdata_r <= mask_high_r;
          MASK_LOW_OFFSET:  ls_rdata_r <= mask_low_r;
          default:          ls_rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // Mode flag and the switch into native mode. Traps outside emulation mode
  // are ignored, and a mode set in emulation mode has nothing to do.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      emu_mode_r   <= 1'b0;
      psw_swap_r   <= 1'b0;
      old_psw_r    <= 64'h0;
      local_trap_r <= 1'b0;
      backup_we_r  <= 1'b0;
      backup_a_r   <= '0;
      backup_b_r   <= '0;
    end else begin
      psw_swap_r   <= 1'b0;
      local_trap_r <= 1'b0;
      backup_we_r  <= 1'b0;
      if (emu_mode_r && trap_event) begin
        if (sw.hit) begin
          emu_mode_r <= 1'b0;
          psw_swap_r <= 1'b1;
          old_psw_r  <= cur_psw;
          old_psw_r[PSW_CODE_LSB +: 8] <= sw.code;
          if (!trap_error_noaddr) begin
            old_psw_r[PSW_ADDR_LSB +: ADDR_WIDTH] <=
              {{(ADDR_WIDTH-EMU_ADDR_WIDTH){1'b0}}, emu_instr_addr};
          end
          backup_we_r <= 1'b1;
          backup_a_r  <= emu_a_in;
          backup_b_r  <= emu_b_in;
        end else begin
          local_trap_r <= 1'b1;
        end
      end else if (!emu_mode_r && mode_set_instr) begin
        emu_mode_r <= 1'b1;
      end
    end
  end

  // Byte mover. Each character costs a storage read, or two for the
  // operations that must look at the destination first; that adds a third
  // storage access per character to the to-operations but keeps one simple storage port.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      kind_r      <= OP_MOVE_TO;
      pend_wm_r   <= 1'b0;
      sep_done_r  <= 1'b0;
      op_busy_r   <= 1'b0;
      op_done_r   <= 1'b0;
      op_cc_r     <= CC_COUNT;
      src_reg_r   <= '0;
      dst_reg_r   <= '0;
      cnt_reg_r   <= '0;
      b_load_r    <= 1'b0;
      b_value_r   <= '0;
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= '0;
      mem_wdata_r <= 8'h00;
      mem_wm_we_r <= 1'b0;
      mem_wm_r    <= 1'b0;
    end else begin
      op_done_r <= 1'b0;
      b_load_r  <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (op_start && !emu_mode_r) begin
            kind_r     <= op_kind;
            src_reg_r  <= op_src;
            dst_reg_r  <= op_dst;
            cnt_reg_r  <= op_count;
            pend_wm_r  <= 1'b0;
            sep_done_r <= 1'b0;
            op_busy_r  <= 1'b1;
            state_r    <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (cnt_reg_r == CNT_ZERO) begin
            if (to_op) begin
              mem_req_r   <= 1'b1;
              mem_we_r    <= 1'b1;
              mem_addr_r  <= dst_reg_r;
              mem_wdata_r <= GROUP_MARK_CHAR;
              mem_wm_we_r <= (kind_r == OP_LOAD_TO);
              mem_wm_r    <= 1'b0;
              state_r     <= ST_WR_GM;
            end else begin
              op_cc_r <= CC_COUNT;
              state_r <= ST_FINISH;
            end
          end else begin
            mem_req_r   <= 1'b1;
            mem_we_r    <= 1'b0;
            mem_wm_we_r <= 1'b0;
            mem_addr_r  <= to_op ? dst_reg_r : src_reg_r;
            state_r     <= to_op ? ST_RD_DST : ST_RD_SRC;
          end
        end
        ST_RD_DST: begin
          if (mem_ack) begin
            if (is_group_mark_with_word_mark) begin
              mem_req_r <= 1'b0;
              dst_reg_r <= dst_reg_r + ADDR_ONE;
              b_value_r <= dst_reg_r + ADDR_ONE;
              b_load_r  <= 1'b1;
              op_cc_r   <= CC_GROUP_MARK_WITH_WORD_MARK;
              state_r   <= ST_FINISH;
            end else begin
              mem_addr_r <= src_reg_r;
              state_r    <= ST_RD_SRC;
            end
          end
        end
        ST_RD_SRC: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            if (!to_op && is_group_mark_with_word_mark) begin
              src_reg_r <= src_reg_r + ADDR_ONE;
              b_value_r <= src_reg_r + ADDR_ONE;
              b_load_r  <= 1'b1;
              op_cc_r   <= CC_GROUP_MARK_WITH_WORD_MARK;
              state_r   <= ST_FINISH;
            end else if (kind_r == OP_LOAD_TO && mem_rdata == WORD_SEP_CHAR) begin
              cnt_reg_r <= cnt_reg_r - CNT_ONE;
              src_reg_r <= src_reg_r + ADDR_ONE;
              pend_wm_r <= 1'b1;
              state_r   <= ST_CHECK;
            end else if (kind_r == OP_LOAD_FROM && mem_rwm && !sep_done_r) begin
              mem_req_r   <= 1'b1;
              mem_we_r    <= 1'b1;
              mem_addr_r  <= dst_reg_r;
              mem_wdata_r <= WORD_SEP_CHAR;
              mem_wm_we_r <= 1'b0;
              sep_done_r  <= 1'b1;
              state_r     <= ST_WR_SEP;
            end else begin
              mem_req_r   <= 1'b1;
              mem_we_r    <= 1'b1;
              mem_addr_r  <= dst_reg_r;
              mem_wdata_r <= mem_rdata;
              mem_wm_we_r <= (kind_r == OP_LOAD_TO);
              mem_wm_r    <= pend_wm_r;
              state_r     <= ST_WR_DAT;
            end
          end
        end
        ST_WR_DAT: begin
          if (mem_ack) begin
            mem_req_r  <= 1'b0;
            src_reg_r  <= src_reg_r + ADDR_ONE;
            dst_reg_r  <= dst_reg_r + ADDR_ONE;
            cnt_reg_r  <= cnt_reg_r - CNT_ONE;
            pend_wm_r  <= 1'b0;
            sep_done_r <= 1'b0;
            state_r    <= ST_CHECK;
          end
        end
        ST_WR_SEP: begin
          // The source stays put so that the marked character follows.
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            dst_reg_r <= dst_reg_r + ADDR_ONE;
            cnt_reg_r <= cnt_reg_r - CNT_ONE;
            state_r   <= ST_CHECK;
          end
        end
        ST_WR_GM: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            dst_reg_r <= dst_reg_r + ADDR_ONE;
            b_value_r <= dst_reg_r + ADDR_ONE;
            b_load_r  <= 1'b1;
            op_cc_r   <= CC_COUNT;
            state_r   <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          mem_we_r    <= 1'b0;
          mem_wm_we_r <= 1'b0;
          op_busy_r   <= 1'b0;
          op_done_r   <= 1'b1;
          state_r     <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : mode_switch_compat_mover

// *** design/compat_pkg.sv ***
// Purpose: Shared constants and types for the mode switch and compatibility mover.
// Assumes: Single processor clock; storage answers on the same clock.
// Notes:   Character codes and cause codes are plain defaults, easily changed here.
package compat_pkg;

  // Local storage mask bytes.
  localparam logic [7:0]  MASK_HIGH_OFFSET  = 8'h9c;
  localparam logic [7:0]  MASK_LOW_OFFSET   = 8'h9d;
  localparam logic [7:0]  MASK_RESET        = 8'h00;

  // Selectable switch causes, in mask bit order from the high byte down.
  localparam logic [3:0]  CAUSE_INVALID_OP  = 4'h0;
  localparam logic [3:0]  CAUSE_HALT_OP     = 4'h1;
  localparam logic [3:0]  CAUSE_ERROR_STOP  = 4'h2;
  localparam logic [3:0]  CAUSE_INVALID_IO  = 4'h3;
  localparam logic [3:0]  CAUSE_CONSOLE_OP  = 4'h4;
  localparam logic [3:0]  CAUSE_PRINTER_OP  = 4'h5;
  localparam logic [3:0]  CAUSE_READER_OP   = 4'h6;
  localparam logic [3:0]  CAUSE_TAPE_OP     = 4'h7;
  localparam logic [3:0]  CAUSE_FILE_OP     = 4'h8;
  localparam int          NUM_CAUSES        = 9;
  localparam int          MASK_MSB          = 15;
  // Code stored in the old status word is this base plus the cause index.
  localparam logic [7:0]  CAUSE_CODE_BASE   = 8'h10;

  // Old status word layout: bits 24-31 in big-endian numbering sit at [39:32].
  localparam int          PSW_CODE_LSB      = 32;
  localparam int          PSW_ADDR_LSB      = 0;

  localparam int          ADDR_WIDTH        = 24;
  localparam int          CNT_WIDTH         = 16;
  localparam int          EMU_ADDR_WIDTH    = 16;

  localparam logic [7:0]  GROUP_MARK_CHAR   = 8'h7f;
  localparam logic [7:0]  WORD_SEP_CHAR     = 8'h5f;
  localparam logic [CNT_WIDTH-1:0]  CNT_ZERO = 16'h0000;
  localparam logic [ADDR_WIDTH-1:0] ADDR_ONE = 24'h000001;
  localparam logic [CNT_WIDTH-1:0]  CNT_ONE  = 16'h0001;

  // Condition code after a move or load.
  localparam logic [1:0]  CC_COUNT          = 2'h0;
  localparam logic [1:0]  CC_GROUP_MARK_WITH_WORD_MARK           = 2'h1;

  typedef enum logic [1:0] {
    OP_MOVE_TO,
    OP_MOVE_FROM,
    OP_LOAD_TO,
    OP_LOAD_FROM
  } move_op_type;

endpackage : compat_pkg

// *** design/switch_if.sv ***
// Purpose: Carries the trap decision between the mover top and the decider.
// Assumes: Purely combinational exchange on one clock.
// Notes:   None.
`timescale 1ns/1ps
interface switch_if;
  logic [15:0] mask;
  logic [3:0]  cause;
  logic        hit;
  logic [7:0]  code;
  modport top    (output mask, output cause, input hit, input code);
  modport decide (input mask, input cause, output hit, output code);
endinterface : switch_if

// *** design/switch_decider.sv ***
// Purpose: Decides whether an emulation trap switches mode, and its cause code.
// Assumes: Cause index is stable in the cycle the trap is presented.
// Notes:   An out-of-range cause never switches.
`timescale 1ns/1ps
module switch_decider
  import compat_pkg::*;
(
  switch_if.decide sw
);

  logic [NUM_CAUSES-1:0] enabled;

  // Cause i is enabled by mask bit 15-i, so the high byte holds the first eight.
  genvar i;
  generate
    for (i = 0; i < NUM_CAUSES; i++) begin : g_cause
      assign enabled[i] = sw.mask[MASK_MSB - i];
    end
  endgenerate

  assign sw.hit  = (int'(sw.cause) < NUM_CAUSES) ? enabled[sw.cause] : 1'b0;
  assign sw.code = CAUSE_CODE_BASE + {4'h0, sw.cause};

endmodule : switch_decider

// *** verif/mem_model.sv ***
// Purpose: Main storage model, one character plus word mark per place.
// Assumes: Requests are held until ack; slow lets ack rise only on every other clock.
// Notes:   Unanswered read lines show the inverse so stale data never passes.
`timescale 1ns/1ps
module mem_model (
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wm_we,
  input  wire logic        wm,
  output logic             ack,
  output logic [7:0]       rdata,
  output logic             rwm
);
  logic [8:0] m [0:1023];
  logic       ph;
  initial begin
    ack = 1'b0;
    ph = 1'b0;
  end
  always @(posedge ref_clk) begin
    ph <= ~ph;
    ack <= req && !ack && (!slow || ph);
    if (req && ack && we) begin
      m[addr[9:0]][7:0] <= wdata;
      if (wm_we) m[addr[9:0]][8] <= wm;
    end
  end
  assign rdata = ack ? m[addr[9:0]][7:0] : ~m[addr[9:0]][7:0];
  assign rwm   = ack ? m[addr[9:0]][8] : ~m[addr[9:0]][8];
endmodule : mem_model

// *** verif/mode_switch_compat_mover_checker.sv ***
// Purpose: Concurrent checks on the ports of the mover top.
// Assumes: The mask shadow follows the local storage writes seen at the ports.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/1ps
module mode_switch_compat_mover_checker
  import compat_pkg::*;
(
  input wire logic                      ref_clk,
  input wire logic                      rst,
  input wire logic                      ls_we,
  input wire logic [7:0]                ls_addr,
  input wire logic [7:0]                ls_wdata,
  input wire logic                      trap_event,
  input wire logic [3:0]                trap_cause,
  input wire logic                      trap_error_noaddr,
  input wire logic [EMU_ADDR_WIDTH-1:0] emu_instr_addr,
  input wire logic [EMU_ADDR_WIDTH-1:0] emu_a_in,
  input wire logic                      mode_set_instr,
  input wire logic                      emu_mode_r,
  input wire logic                      psw_swap_r,
  input wire logic [63:0]               old_psw_r,
  input wire logic                      local_trap_r,
  input wire logic                      backup_we_r,
  input wire logic [EMU_ADDR_WIDTH-1:0] backup_a_r,
  input wire logic                      op_start,
  input move_op_type                    op_kind,
  input wire logic                      op_busy_r,
  input wire logic                      op_done_r,
  input wire logic                      mem_req_r,
  input wire logic                      mem_we_r,
  input wire logic                      mem_wm_we_r
);
  logic [15:0] mask_r;
  move_op_type kind_r;
  logic        en;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) mask_r <= 16'h0000;
    else if (ls_we && ls_addr == MASK_HIGH_OFFSET) mask_r[15:8] <= ls_wdata;
    else if (ls_we && ls_addr == MASK_LOW_OFFSET) mask_r[7:0] <= ls_wdata;
  end
  // The kind is latched because op_kind may change once a command is taken.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) kind_r <= OP_MOVE_TO;
    else if (op_start && !op_busy_r && !emu_mode_r) kind_r <= op_kind;
  end
  assign en = trap_event && emu_mode_r && trap_cause < 4'h9 && mask_r[4'hf - trap_cause];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_switched;
    psw_swap_r && backup_we_r && !emu_mode_r;
  endsequence
  property p_switch; en |=> s_switched; endproperty
  a_switch: assert property (p_switch) else $error("trap did not switch");
  property p_local;
    trap_event && emu_mode_r && !en |=> local_trap_r && !psw_swap_r && emu_mode_r;
  endproperty
  a_local: assert property (p_local) else $error("masked trap switched");
  property p_code; en |=> old_psw_r[39:32] == CAUSE_CODE_BASE + {4'h0, $past(trap_cause)};
  endproperty
  a_code: assert property (p_code) else $error("wrong cause code");
  property p_addr;
    en && !trap_error_noaddr |=> old_psw_r[23:0] == {8'h00, $past(emu_instr_addr)};
  endproperty
  a_addr: assert property (p_addr) else $error("wrong stored address");
  property p_backup; psw_swap_r |-> backup_a_r == $past(emu_a_in); endproperty
  a_backup: assert property (p_backup) else $error("wrong backup");
  property p_return; $rose(emu_mode_r) |-> $past(mode_set_instr); endproperty
  a_return: assert property (p_return) else $error("unbidden return");
  property p_wm; mem_req_r && mem_we_r && kind_r == OP_MOVE_TO |-> !mem_wm_we_r; endproperty
  a_wm: assert property (p_wm) else $error("move wrote a word mark");
  property p_done; op_done_r |-> !op_busy_r && $past(op_busy_r); endproperty
  a_done: assert property (p_done) else $error("done without busy");
endmodule : mode_switch_compat_mover_checker

bind mode_switch_compat_mover mode_switch_compat_mover_checker u_chk (
  .ref_clk, .rst, .ls_we, .ls_addr, .ls_wdata, .trap_event, .trap_cause,
  .trap_error_noaddr, .emu_instr_addr, .emu_a_in, .mode_set_instr, .emu_mode_r,
  .psw_swap_r, .old_psw_r, .local_trap_r, .backup_we_r, .backup_a_r, .op_start,
  .op_kind, .op_busy_r, .op_done_r, .mem_req_r, .mem_we_r, .mem_wm_we_r);

// *** verif/tb_mode_switch_compat_mover.sv ***
// Purpose: Self-checking bench for mode switching and the four movers.
// Assumes: Storage is the partner model; traps always come from emulation mode.
// Notes:   Expected storage contents are read straight from the model array.
`timescale 1ns/1ps
module tb_mode_switch_compat_mover;
  import compat_pkg::*;
  logic        ref_clk, rst, ls_we, ls_re, trap_event, trap_error_noaddr;
  logic        mode_set_instr, op_start, slow, emu_mode_r, psw_swap_r, local_trap_r;
  logic        backup_we_r, op_busy_r, op_done_r, b_load_r, mem_req_r, mem_we_r;
  logic        mem_wm_we_r, mem_wm_r, mem_ack, mem_rwm;
  logic [1:0]  op_cc_r;
  logic [3:0]  trap_cause;
  logic [7:0]  ls_addr, ls_wdata, ls_rdata_r, mem_wdata_r, mem_rdata;
  logic [15:0] emu_instr_addr, emu_a_in, emu_b_in, backup_a_r, backup_b_r;
  logic [15:0] op_count, cnt_reg_r;
  logic [23:0] op_src, op_dst, src_reg_r, dst_reg_r, b_value_r, mem_addr_r;
  logic [63:0] cur_psw, old_psw_r;
  move_op_type op_kind;
  int          errors, checked, b_seen;
  localparam logic [8:0] GROUP_MARK_WITH_WORD_MARK = {1'b1, GROUP_MARK_CHAR};

  mode_switch_compat_mover dut (.*);
  mem_model mem (.ref_clk, .slow, .req(mem_req_r), .we(mem_we_r), .addr(mem_addr_r),
    .wdata(mem_wdata_r), .wm_we(mem_wm_we_r), .wm(mem_wm_r), .ack(mem_ack),
    .rdata(mem_rdata), .rwm(mem_rwm));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task ls(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    ls_we <= we;
    ls_re <= !we;
    ls_addr <= a;
    ls_wdata <= d;
    @(posedge ref_clk);
    ls_we <= 1'b0;
    ls_re <= 1'b0;
    #1;
  endtask : ls

  // Mode set first; in emulation mode it is ignored, so traps can repeat.
  task trap(input logic [3:0] c, input logic na);
    @(posedge ref_clk);
    mode_set_instr <= 1'b1;
    @(posedge ref_clk);
    mode_set_instr <= 1'b0;
    trap_event <= 1'b1;
    trap_cause <= c;
    trap_error_noaddr <= na;
    emu_instr_addr <= 16'h1230 + c;
    emu_a_in <= 16'ha000 + c;
    @(posedge ref_clk);
    trap_event <= 1'b0;
    #1;
  endtask : trap

  task run(input move_op_type k, input logic [23:0] s, input logic [23:0] d,
           input logic [15:0] n);
    @(posedge ref_clk);
    op_start <= 1'b1;
    op_kind <= k;
    op_src <= s;
    op_dst <= d;
    op_count <= n;
    @(posedge ref_clk);
    op_start <= 1'b0;
    #1;
    chk(op_busy_r, 1'b1);
    b_seen = 0;
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      #1;
      if (b_load_r === 1'b1) b_seen++;
      if (op_done_r === 1'b1) return;
    end
    errors++;
    report_and_stop;
  endtask : run

  task t_regs;
    ls(1'b0, MASK_HIGH_OFFSET, 8'h00);
    chk(ls_rdata_r, MASK_RESET);
    ls(1'b1, MASK_LOW_OFFSET, 8'h7f);
    ls(1'b1, 8'h9e, 8'h55);
    ls(1'b0, MASK_LOW_OFFSET, 8'h00);
    chk(ls_rdata_r, 8'h7f);
    ls(1'b0, 8'h9e, 8'h00);
    chk(ls_rdata_r, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task t_switch;
    trap(4'h8, 1'b0);
    chk({local_trap_r, psw_swap_r, emu_mode_r}, 3'b101);
    trap(4'h9, 1'b0);
    chk({local_trap_r, emu_mode_r}, 2'b11);
    ls(1'b1, MASK_HIGH_OFFSET, 8'hff);
    ls(1'b1, MASK_LOW_OFFSET, 8'h80);
    for (int i = 0; i < 9; i++) begin
      trap(i[3:0], 1'b0);
      chk({psw_swap_r, emu_mode_r}, 2'b10);
      chk(old_psw_r[39:32], CAUSE_CODE_BASE + i);
      chk(old_psw_r[23:0], 24'h001230 + i);
      chk(backup_a_r, 16'ha000 + i);
      chk(backup_b_r, 16'h5a5a);
    end
    trap(4'h2, 1'b1);
    chk(old_psw_r[23:0], cur_psw[23:0]);
    chk(old_psw_r[63:40], cur_psw[63:40]);
    $display("test switch done");
  endtask : t_switch

  task t_move;
    mem.m[257] = 9'h100;
    mem.m[512] = 9'h141;
    mem.m[513] = 9'h042;
    mem.m[514] = 9'h043;
    run(OP_MOVE_TO, 24'h200, 24'h100, 16'h0003);
    chk(mem.m[256], 9'h041);
    chk(mem.m[257], 9'h142);
    chk(mem.m[259], {1'b0, GROUP_MARK_CHAR});
    chk({src_reg_r, dst_reg_r, cnt_reg_r}, {24'h203, 24'h104, 16'h0});
    chk({b_value_r, op_cc_r}, {24'h104, CC_COUNT});
    chk(b_seen, 1);
    mem.m[273] = GROUP_MARK_WITH_WORD_MARK;
    mem.m[528] = 9'h044;
    run(OP_MOVE_TO, 24'h210, 24'h110, 16'h0005);
    chk(mem.m[273], GROUP_MARK_WITH_WORD_MARK);
    chk({src_reg_r, dst_reg_r, cnt_reg_r}, {24'h211, 24'h112, 16'h4});
    chk({b_value_r, op_cc_r}, {24'h112, CC_GROUP_MARK_WITH_WORD_MARK});
    run(OP_MOVE_TO, 24'h220, 24'h120, 16'h0000);
    chk({mem.m[288][7:0], dst_reg_r}, {GROUP_MARK_CHAR, 24'h121});
    mem.m[304] = 9'h046;
    mem.m[305] = 9'h047;
    mem.m[306] = GROUP_MARK_WITH_WORD_MARK;
    run(OP_MOVE_FROM, 24'h130, 24'h230, 16'h0005);
    chk(mem.m[561][7:0], 8'h47);
    chk({src_reg_r, dst_reg_r, cnt_reg_r}, {24'h133, 24'h232, 16'h3});
    chk({b_value_r, op_cc_r}, {24'h133, CC_GROUP_MARK_WITH_WORD_MARK});
    mem.m[578] = 9'h0aa;
    run(OP_MOVE_FROM, 24'h140, 24'h240, 16'h0002);
    chk({mem.m[578], op_cc_r}, {9'h0aa, CC_COUNT});
    chk(b_seen, 0);
    $display("test move done");
  endtask : t_move

  task t_load;
    mem.m[592] = 9'h041;
    mem.m[593] = {1'b0, WORD_SEP_CHAR};
    mem.m[594] = 9'h042;
    for (int i = 336; i < 339; i++) mem.m[i] = 9'h1ff;
    run(OP_LOAD_TO, 24'h250, 24'h150, 16'h0003);
    chk(mem.m[336], 9'h041);
    chk(mem.m[337], 9'h142);
    chk(mem.m[338], {1'b0, GROUP_MARK_CHAR});
    chk({src_reg_r, dst_reg_r, cnt_reg_r}, {24'h253, 24'h153, 16'h0});
    chk(b_value_r, 24'h153);
    slow <= 1'b1;
    mem.m[352] = 9'h141;
    mem.m[353] = 9'h042;
    mem.m[354] = GROUP_MARK_WITH_WORD_MARK;
    run(OP_LOAD_FROM, 24'h160, 24'h260, 16'h0005);
    slow <= 1'b0;
    chk(mem.m[608][7:0], WORD_SEP_CHAR);
    chk(mem.m[609][7:0], 8'h41);
    chk({src_reg_r, dst_reg_r, cnt_reg_r}, {24'h163, 24'h263, 16'h2});
    chk({b_value_r, op_cc_r}, {24'h163, CC_GROUP_MARK_WITH_WORD_MARK});
    $display("test load done");
  endtask : t_load

  initial begin
    rst = 1'b1;
    {ls_we, ls_re, trap_event, trap_error_noaddr, mode_set_instr, op_start, slow} = 7'h00;
    ls_addr = 8'h00;
    ls_wdata = 8'h00;
    trap_cause = 4'h0;
    emu_instr_addr = 16'h0000;
    emu_a_in = 16'h0000;
    emu_b_in = 16'h5a5a;
    cur_psw = 64'h0123456789abcdef;
    op_kind = OP_MOVE_TO;
    op_src = 24'h000000;
    op_dst = 24'h000000;
    op_count = 16'h0000;
    errors = 0;
    checked = 0;
    for (int i = 0; i < 1024; i++) mem.m[i] = 9'h000;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_switch;
    t_move;
    t_load;
    report_and_stop;
  end
endmodule : tb_mode_switch_compat_mover
